/* hw/dwp_pkg.sv */
// dwp_pkg: constants and types of the waveform playback sequencer
// assumes a single 200 MHz clock domain shared by every user of the package
package dwp_pkg;

	// ==========================================================
	// word and memory layout
	localparam int WORD_W = 16;
	localparam int CODE_W = 12;
	localparam int NIB_W = 4;
	localparam int BANK_AW = 16;
	localparam int MEM_AW = 17;
	localparam int CHAN_W = 3;
	localparam int NUM_CHAN = 8;
	localparam int BIT_HALT = 15;
	localparam int BIT_FRAME = 14;
	localparam int BIT_WRAP = 13;
	localparam int BIT_LOOP = 12;
	localparam int NIB_LSB = 12;
	localparam logic [3:0] NIB_BLANK_ON = 4'hB;
	localparam logic [3:0] NIB_BLANK_OFF = 4'h9;
	localparam logic [3:0] NIB_RSV_A = 4'hD;
	localparam logic [3:0] NIB_RSV_B = 4'hF;
	localparam logic [11:0] ZERO_CODE = 12'h000;

	// ==========================================================
	// register port
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_WADDR = 8'h08;
	localparam logic [7:0] REG_WDATA = 8'h0C;
	localparam logic [7:0] REG_RPTR = 8'h10;
	localparam logic [7:0] REG_DIV = 8'h14;
	localparam logic [7:0] REG_DACW = 8'h18;
	localparam logic [7:0] REG_DACUPD = 8'h1C;
	localparam int CTRL_PLAY = 0;
	localparam int CTRL_STOP = 1;
	localparam int CTRL_ILK_EN = 2;
	localparam int CTRL_SIMUL = 3;
	localparam int ST_PLAYING = 0;
	localparam int ST_PAUSED = 1;
	localparam int ST_LEADIN = 2;
	localparam int ST_CHAN_LSB = 4;
	localparam int DACW_CH_LSB = 16;
	localparam int DIV_W = 16;
	localparam logic [15:0] DIV_RESET = 16'h00C7;

	// ==========================================================
	// timing
	localparam int CLK_NS = 5;
	localparam int LEADIN_US = 500;
	localparam int LEADIN_CYCLES = (LEADIN_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int LEADIN_W = 17;

	typedef enum logic [1:0] {st_idle, st_run, st_read, st_apply} dwp_state_type;

	// combinations that act as individual flags
	function automatic logic dwp_ordinary(input logic [3:0] nib);
		return !(nib == NIB_BLANK_ON || nib == NIB_BLANK_OFF || nib == NIB_RSV_A ||
			nib == NIB_RSV_B);
	endfunction

endpackage

/* hw/dwp_mem_if.sv */
// dwp_mem_if: one waveform bank, write side and read side
// assumes the sequencer clock drives both sides
`timescale 1ns/1ps
interface dwp_mem_if;
	import dwp_pkg::*;
	logic we;
	logic [BANK_AW-1:0] waddr;
	logic [WORD_W-1:0] wdata;
	logic [BANK_AW-1:0] raddr;
	logic [WORD_W-1:0] rdata;
	modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* hw/dwp_bank.sv */
// dwp_bank: 64k-word dual-port bank, registered read
// assumes writes and reads may occur in the same cycle
`timescale 1ns/1ps
module dwp_bank
	import dwp_pkg::*;
(
	// clock
	input wire logic clk,
	// bank port
	dwp_mem_if.mem port
);
	logic [WORD_W-1:0] store [0:(1<<BANK_AW)-1];
	logic [WORD_W-1:0] rdata_r;

	// ==========================================================
	// write side
	always_ff @(posedge clk) begin
		if (port.we) begin
			store[port.waddr] <= port.wdata;
		end
	end

	// ==========================================================
	// read side
	always_ff @(posedge clk) begin
		rdata_r <= store[port.raddr];
	end
	assign port.rdata = rdata_r;
endmodule

/* hw/dwp_seq.sv */
// dwp_seq: waveform playback sequencer for eight 12-bit outputs
// assumes control pins are asynchronous and the register port is on clk
`timescale 1ns/1ps
// Function
// - word: bit15 halt, 14 frame, 13 wrap, 12 loop, 11..0 code
// - two 64k-word banks form one 128k-word memory loaded by software
// - one word fetched per timer tick, code sent to current channel
// - playback starts on play command or trigger falling edge
// - pause pin low suspends playback and pointer advance
// - channels 0 to 7 in order; wrap flag returns next word to 0
// - wrap status output set by a played wrap flag
// - frame status output set by a played frame flag
// - halt flag stops playback after its word is output
// - without halt the pointer rolls over and repeats forever
// - loop flag with looping enabled returns pointer to first word
// - loop-enable pin low makes loop flags ignored
// - interlock enabled and pin high forces zero codes
// - nibble 1011 sets blank output, 1001 clears it
// - manual writes update at once or all together on update
// - outputs clamped to zero for about 500 us after reset
// - frame and wrap outputs hold until next channel 0 word
module dwp_seq
	import dwp_pkg::*;
#(
	parameter int unsigned LEADIN = LEADIN_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// control pins
	input wire logic trig_n,
	input wire logic pause_n,
	input wire logic interlock,
	input wire logic loop_en,
	// status pins
	output logic frame_out,
	output logic wrap_out,
	output logic blank_out,
	// converter codes
	output logic [NUM_CHAN-1:0][CODE_W-1:0] dac_code
);
	dwp_state_type state_r;
	logic [2:0] trig_sy_r, pause_sy_r, ilk_sy_r, loop_sy_r;
	logic ilk_en_r, simul_r;
	logic [MEM_AW-1:0] waddr_r, rptr_r;
	logic [DIV_W-1:0] div_r, div_cnt_r;
	logic [CHAN_W-1:0] chan_r;
	logic [NUM_CHAN-1:0][CODE_W-1:0] dac_val_r, dac_load_r, dac_code_r;
	logic frame_r, wrap_r, blank_r;
	logic [LEADIN_W-1:0] leadin_r;
	logic [DATA_W-1:0] rdata_r;
	logic trig_fall, paused, loop_on, ilk_s, start, stop_cmd, tick, mem_we, clamp;
	logic [WORD_W-1:0] word;
	logic [NIB_W-1:0] nib;
	logic ord, f_halt, f_frame, f_wrap, f_loop;

	dwp_mem_if bank0 ();
	dwp_mem_if bank1 ();

	dwp_bank u_bank0 (
		.clk(clk),
		.port(bank0.mem)
	);
	dwp_bank u_bank1 (
		.clk(clk),
		.port(bank1.mem)
	);

	// ==========================================================
	// pin synchronisers
	always_ff @(posedge clk) begin
		if (rst) begin
			trig_sy_r <= 3'h7;
			pause_sy_r <= 3'h7;
			ilk_sy_r <= 3'h7;
			loop_sy_r <= 3'h7;
		end else begin
			trig_sy_r <= {trig_sy_r[1:0], trig_n};
			pause_sy_r <= {pause_sy_r[1:0], pause_n};
			ilk_sy_r <= {ilk_sy_r[1:0], interlock};
			loop_sy_r <= {loop_sy_r[1:0], loop_en};
		end
	end
	assign trig_fall = trig_sy_r[2] && !trig_sy_r[1];
	assign paused = !pause_sy_r[1];
	assign loop_on = loop_sy_r[1];
	assign ilk_s = ilk_sy_r[1];

	// ==========================================================
	// register decode
	assign start = trig_fall || (reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_PLAY]);
	assign stop_cmd = reg_wr && reg_addr == REG_CTRL && reg_wdata[CTRL_STOP];
	assign mem_we = reg_wr && reg_addr == REG_WDATA;

	always_ff @(posedge clk) begin
		if (rst) begin
			ilk_en_r <= 1'b0;
			simul_r <= 1'b0;
			div_r <= DIV_RESET;
		end else if (reg_wr && reg_addr == REG_CTRL) begin
			ilk_en_r <= reg_wdata[CTRL_ILK_EN];
			simul_r <= reg_wdata[CTRL_SIMUL];
		end else if (reg_wr && reg_addr == REG_DIV) begin
			div_r <= reg_wdata[DIV_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			waddr_r <= '0;
		end else if (reg_wr && reg_addr == REG_WADDR) begin
			waddr_r <= reg_wdata[MEM_AW-1:0];
		end else if (mem_we) begin
			waddr_r <= waddr_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_r <= '0;
		end else if (!reg_rd) begin
			rdata_r <= '0;
		end else if (reg_addr == REG_CTRL) begin
			rdata_r <= DATA_W'({simul_r, ilk_en_r}) << CTRL_ILK_EN;
		end else if (reg_addr == REG_STATUS) begin
			rdata_r <= (DATA_W'(chan_r) << ST_CHAN_LSB) |
				(DATA_W'(leadin_r != '0) << ST_LEADIN) |
				(DATA_W'(paused) << ST_PAUSED) |
				(DATA_W'(state_r != st_idle) << ST_PLAYING);
		end else if (reg_addr == REG_WADDR) begin
			rdata_r <= DATA_W'(waddr_r);
		end else if (reg_addr == REG_RPTR) begin
			rdata_r <= DATA_W'(rptr_r);
		end else if (reg_addr == REG_DIV) begin
			rdata_r <= DATA_W'(div_r);
		end else begin
			rdata_r <= '0;
		end
	end
	assign reg_rdata = rdata_r;

	// ==========================================================
	// waveform memory, two banks on address bit 16
	assign bank0.we = mem_we && !waddr_r[BANK_AW];
	assign bank1.we = mem_we && waddr_r[BANK_AW];
	assign bank0.waddr = waddr_r[BANK_AW-1:0];
	assign bank1.waddr = waddr_r[BANK_AW-1:0];
	assign bank0.wdata = reg_wdata[WORD_W-1:0];
	assign bank1.wdata = reg_wdata[WORD_W-1:0];
	assign bank0.raddr = rptr_r[BANK_AW-1:0];
	assign bank1.raddr = rptr_r[BANK_AW-1:0];
	assign word = rptr_r[BANK_AW] ? bank1.rdata : bank0.rdata;

	// ==========================================================
	// word decode
	assign nib = word[WORD_W-1:NIB_LSB];
	assign ord = dwp_ordinary(nib);
	assign f_halt = ord && word[BIT_HALT];
	assign f_frame = ord && word[BIT_FRAME];
	assign f_wrap = ord && word[BIT_WRAP];
	assign f_loop = ord && word[BIT_LOOP];

	// ==========================================================
	// tick timer
	assign tick = div_cnt_r == div_r;
	always_ff @(posedge clk) begin
		if (rst || start || state_r == st_idle || tick) begin
			div_cnt_r <= '0;
		end else if (!paused) begin
			div_cnt_r <= div_cnt_r + 1'b1;
		end
	end

	// ==========================================================
	// playback sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= st_idle;
		end else if (stop_cmd) begin
			state_r <= st_idle;
		end else if (start) begin
			state_r <= st_run;
		end else begin
			case (state_r)
				st_run: if (tick && !paused) state_r <= st_read;
				st_read: state_r <= st_apply;
				st_apply: state_r <= f_halt ? st_idle : st_run;
				default: state_r <= st_idle;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst || start) begin
			rptr_r <= '0;
		end else if (state_r == st_apply && !stop_cmd) begin
			if (f_loop && loop_on) begin
				rptr_r <= '0;
			end else begin
				rptr_r <= rptr_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst || start) begin
			chan_r <= '0;
		end else if (state_r == st_apply && !stop_cmd) begin
			chan_r <= f_wrap ? '0 : chan_r + 1'b1;
		end
	end

	// ==========================================================
	// status pins
	always_ff @(posedge clk) begin
		if (rst) begin
			frame_r <= 1'b0;
			wrap_r <= 1'b0;
		end else if (state_r == st_apply && !stop_cmd && !start) begin
			frame_r <= (chan_r != '0 && frame_r) || f_frame;
			wrap_r <= (chan_r != '0 && wrap_r) || f_wrap;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			blank_r <= 1'b0;
		end else if (state_r == st_apply && !stop_cmd && !start) begin
			if (nib == NIB_BLANK_ON) begin
				blank_r <= 1'b1;
			end else if (nib == NIB_BLANK_OFF) begin
				blank_r <= 1'b0;
			end
		end
	end
	assign frame_out = frame_r;
	assign wrap_out = wrap_r;
	assign blank_out = blank_r;

	// ==========================================================
	// channel values, manual and playback
	always_ff @(posedge clk) begin
		if (rst) begin
			dac_load_r <= '0;
			dac_val_r <= '0;
		end else begin
			if (reg_wr && reg_addr == REG_DACW) begin
				if (simul_r) begin
					dac_load_r[reg_wdata[DACW_CH_LSB +: CHAN_W]] <= reg_wdata[CODE_W-1:0];
				end else begin
					dac_val_r[reg_wdata[DACW_CH_LSB +: CHAN_W]] <= reg_wdata[CODE_W-1:0];
				end
			end else if (reg_wr && reg_addr == REG_DACUPD) begin
				dac_val_r <= dac_load_r;
			end
			if (state_r == st_apply && !stop_cmd && !start) begin
				dac_val_r[chan_r] <= word[CODE_W-1:0];
			end
		end
	end

	// ==========================================================
	// power-up lead-in and interlock clamp
	always_ff @(posedge clk) begin
		if (rst) begin
			leadin_r <= LEADIN_W'(LEADIN);
		end else if (leadin_r != '0) begin
			leadin_r <= leadin_r - 1'b1;
		end
	end
	assign clamp = leadin_r != '0 || (ilk_en_r && ilk_s);

	always_ff @(posedge clk) begin
		if (rst) begin
			dac_code_r <= {NUM_CHAN{ZERO_CODE}};
		end else if (clamp) begin
			dac_code_r <= {NUM_CHAN{ZERO_CODE}};
		end else begin
			dac_code_r <= dac_val_r;
		end
	end
	assign dac_code = dac_code_r;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_tick_run;
		state_r == st_run && tick && !paused && !start && !stop_cmd;
	endsequence
	sequence s_fetch_done;
		##1 state_r == st_read ##1 (state_r == st_apply || $past(start) || $past(stop_cmd));
	endsequence
	sequence s_apply_ok;
		state_r == st_apply && !start && !stop_cmd;
	endsequence

	property p_fetch;
		s_tick_run |-> s_fetch_done;
	endproperty
	a_fetch: assert property (p_fetch) else $error("tick did not fetch a word");

	property p_code;
		s_apply_ok |=> dac_val_r[$past(chan_r)] == $past(word[CODE_W-1:0]);
	endproperty
	a_code: assert property (p_code) else $error("code not sent to channel");

	property p_start;
		start && !stop_cmd |=> state_r == st_run && rptr_r == '0 && chan_r == '0;
	endproperty
	a_start: assert property (p_start) else $error("start not from word zero");

	property p_pause;
		state_r == st_run && paused && !start && !stop_cmd |=> $stable(rptr_r) && state_r != st_read;
	endproperty
	a_pause: assert property (p_pause) else $error("pointer moved while paused");

	property p_halt;
		s_apply_ok and f_halt |=> state_r == st_idle;
	endproperty
	a_halt: assert property (p_halt) else $error("halt flag ignored");

	property p_wrap;
		s_apply_ok and f_wrap |=> chan_r == '0 && wrap_r;
	endproperty
	a_wrap: assert property (p_wrap) else $error("wrap flag not honoured");

	property p_frame_hold;
		frame_r && !(state_r == st_apply && chan_r == '0) |=> frame_r;
	endproperty
	a_frame_hold: assert property (p_frame_hold) else $error("frame dropped early");

	property p_loop;
		s_apply_ok and f_loop and !loop_on |=> rptr_r == $past(rptr_r) + 1'b1;
	endproperty
	a_loop: assert property (p_loop) else $error("loop flag used while disabled");

	property p_blank;
		s_apply_ok and nib == NIB_BLANK_ON |=> blank_r ##1 blank_r;
	endproperty
	a_blank: assert property (p_blank) else $error("blank not set");

	property p_clamp;
		ilk_en_r && ilk_s |=> dac_code_r == {NUM_CHAN{ZERO_CODE}};
	endproperty
	a_clamp: assert property (p_clamp) else $error("interlock did not zero outputs");
endmodule

/* bench/dwp_pins_model.sv */
// dwp_pins_model: far-side control pins with pull-ups, set on request
// assumes requests change just after rising edges of clk
`timescale 1ns/1ps
module dwp_pins_model (
	// clock and requests
	input wire logic clk,
	input wire logic fire,
	input wire logic hold,
	input wire logic ilk_low,
	input wire logic loop_off,
	// pins
	output logic trig_n,
	output logic pause_n,
	output logic interlock,
	output logic loop_en
);
	logic [2:0] low_cnt = 3'h0;

	// ==========================================================
	// trigger pulled low a few cycles, then back to the pull-up
	always @(posedge clk) begin
		if (fire) begin
			low_cnt <= 3'h5;
		end else if (low_cnt != 3'h0) begin
			low_cnt <= low_cnt - 3'h1;
		end
	end
	assign trig_n = (low_cnt == 3'h0);
	assign pause_n = !hold;
	assign interlock = !ilk_low;
	assign loop_en = !loop_off;
endmodule

/* bench/test_dac_waveform_playback_sequencer.sv */
// test_dac_waveform_playback_sequencer: self-checking bench
// assumes dwp_seq with a short lead-in and the pin model beside it
`timescale 1ns/1ps
module test_dac_waveform_playback_sequencer;
	import dwp_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata;
	logic fire = 1'b0;
	logic hold = 1'b0;
	logic ilk_low = 1'b0;
	logic loop_off = 1'b0;
	logic trig_n;
	logic pause_n;
	logic interlock;
	logic loop_en;
	logic frame_out;
	logic wrap_out;
	logic blank_out;
	logic [NUM_CHAN-1:0][CODE_W-1:0] dac_code;
	logic [CODE_W-1:0] c [0:4];
	logic [WORD_W-1:0] q [$];
	logic [DATA_W-1:0] rv;
	int miscompares = 0;
	int tests_run = 0;
	int cyc = 0;

	// ==========================================================
	// design and pins
	dwp_seq #(.LEADIN(20)) u_dwp_seq (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.trig_n(trig_n), .pause_n(pause_n), .interlock(interlock), .loop_en(loop_en),
		.frame_out(frame_out), .wrap_out(wrap_out), .blank_out(blank_out),
		.dac_code(dac_code));
	dwp_pins_model u_dwp_pins_model (.clk(clk), .fire(fire), .hold(hold),
		.ilk_low(ilk_low), .loop_off(loop_off), .trig_n(trig_n), .pause_n(pause_n),
		.interlock(interlock), .loop_en(loop_en));

	initial begin
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// tasks
	function automatic logic [WORD_W-1:0] wd(input logic [3:0] n, input logic [CODE_W-1:0] v);
		return {(n == NIB_RSV_A || n == NIB_RSV_B) ? 4'h0 : n, v};
	endfunction

	task automatic chk(input string what, input logic [95:0] exp, input logic [95:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up();
		if (miscompares == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic load();
		wr(REG_WADDR, 32'h0);
		foreach (q[i]) wr(REG_WDATA, {16'h0, q[i]});
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			rd(REG_STATUS, rv);
			n++;
		end while (rv[ST_PLAYING] !== 1'b0 && n < 60);
		chk("playing", 0, rv[ST_PLAYING]);
		tick(2);
	endtask

	task automatic play();
		wr(REG_CTRL, 32'h1);
		wait_idle();
	endtask

	// ==========================================================
	// timeout
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ==========================================================
	// scenarios
	initial begin
		void'($urandom(94));
		for (int i = 0; i < 5; i++) c[i] = CODE_W'($urandom());
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		wr(REG_DACW, {13'h0, 3'h3, 4'h0, c[0]});
		tick(3);
		chk("leadin", 0, dac_code);
		tick(25);
		chk("manual ch3", c[0], dac_code[3]);
		rd(REG_DIV, rv);
		chk("div reset", DIV_RESET, rv);
		rd(8'h40, rv);
		chk("unmapped", 0, rv);
		wr(REG_CTRL, 32'h8);
		wr(REG_DACW, {13'h0, 3'h5, 4'h0, c[1]});
		tick(3);
		chk("staged ch5", 0, dac_code[5]);
		wr(REG_DACUPD, 32'h0);
		tick(2);
		chk("update ch5", c[1], dac_code[5]);
		wr(REG_CTRL, 32'h0);
		wr(REG_DIV, 32'h0);
		q = '{wd(4'h0, c[0]), wd(4'h0, c[1]), wd(4'h2, c[2]), wd(4'h4, c[3]), wd(4'h8, c[4])};
		load();
		play();
		chk("seq codes", {c[2], c[4], c[3]}, {dac_code[2], dac_code[1], dac_code[0]});
		chk("frame wrap", 2'b10, {frame_out, wrap_out});
		q = '{wd(4'h0, c[4]), wd(4'hA, c[0])};
		load();
		@(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		tick(8);
		wait_idle();
		chk("trig codes", {c[0], c[4]}, {dac_code[1], dac_code[0]});
		chk("trig flags", 2'b01, {frame_out, wrap_out});
		for (int k = 0; k < 2; k++) begin
			q = '{wd(k ? 4'h9 : 4'hB, c[k]), wd(4'h8, c[k + 1])};
			load();
			play();
			chk("blank", (k == 0), blank_out);
			chk("blank no halt", c[k + 1], dac_code[1]);
		end
		q = '{wd(4'h0, c[0]), wd(4'h1, c[1]), wd(4'h8, c[2])};
		load();
		@(posedge clk);
		loop_off <= 1'b1;
		play();
		chk("loop off", c[2], dac_code[2]);
		wr(REG_DACW, {13'h0, 3'h2, 4'h0, 12'h000});
		@(posedge clk);
		loop_off <= 1'b0;
		q = '{wd(4'h0, c[0]), wd(4'h1, c[1])};
		load();
		wr(REG_CTRL, 32'h1);
		tick(60);
		rd(REG_STATUS, rv);
		chk("looping", 1, rv[ST_PLAYING]);
		chk("loop restarts ch2", c[0], dac_code[2]);
		wr(REG_WADDR, 32'h0);
		wr(REG_WDATA, {16'h0, wd(4'h0, c[3])});
		tick(30);
		chk("stream write ch0", c[3], dac_code[0]);
		wr(REG_CTRL, 32'h2);
		wait_idle();
		@(posedge clk);
		loop_off <= 1'b1;
		hold <= 1'b1;
		tick(4);
		wr(REG_CTRL, 32'h1);
		tick(30);
		rd(REG_RPTR, rv);
		chk("paused ptr", 0, rv);
		rd(REG_STATUS, rv);
		chk("paused", 2'b11, rv[1:0]);
		@(posedge clk);
		hold <= 1'b0;
		wait_idle();
		chk("resumed", c[2], dac_code[2]);
		wr(REG_CTRL, 32'h4);
		tick(4);
		chk("interlock", 0, dac_code);
		@(posedge clk);
		ilk_low <= 1'b1;
		tick(4);
		chk("interlock low", c[2], dac_code[2]);
		wr(REG_WADDR, 32'h1FFFF);
		wr(REG_WDATA, {16'h0, wd(4'h8, c[3])});
		wr(REG_WDATA, {16'h0, wd(4'h8, c[3])});
		rd(REG_WADDR, rv);
		chk("waddr wrap", 1, rv);
		wrap_up();
	end
endmodule
